//--- iofw_bus_agent.sv
// Behavioural initiator standing for the masters on all three buses.
// Assumes the bench calls issue() from one process at a time.
module iofw_bus_agent (
  input wire logic core_clk_in,
  output logic req_valid_out,
  output iofw_pkg::iofw_bus_t req_origin_out,
  output logic req_is_io_out,
  output logic [31:0] req_addr_out,
  output logic [1:0] mem_win_hit_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    req_valid_out = 1'b0;
    req_origin_out = iofw_pkg::iofw_bus_none;
    req_is_io_out = 1'b0;
    req_addr_out = 32'h0000_0000;
    mem_win_hit_out = 2'b00;
  end
  // Idle address and window-hit lines show the inverse of the last value so stale data is caught.
  task automatic issue(input logic [1:0] o, input logic i,
      input logic [31:0] a, input logic [1:0] m, input int g);
    repeat (g + 1) @(negedge core_clk_in);
    req_valid_out = 1'b1;
    req_origin_out = iofw_pkg::iofw_bus_t'(o);
    req_is_io_out = i;
    req_addr_out = a;
    mem_win_hit_out = m;
    @(negedge core_clk_in);
    req_valid_out = 1'b0;
    req_addr_out = ~a;
    mem_win_hit_out = ~m;
  endtask
endmodule

//--- iofw_cfg_regs.sv
// One secondary port's I/O base and limit registers.
// Assumes single-cycle configuration dword accesses from the top module.
`include "iofw_defines.svh"

module iofw_cfg_regs (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic wr_in,
  input wire logic [5:0] dw_addr_in,
  input wire logic [3:0] be_in,
  input wire logic [31:0] wdata_in,
  output logic [31:0] rdata_out,
  iofw_win_if.src win
);

  iofw_pkg::iofw_win_regs_t st_r;
  iofw_pkg::iofw_win_regs_t st_nxt;

  // Selects a byte lane of a configuration offset when that dword is hit.
  function automatic logic lane_hit(input logic [5:0] dw,
                                    input logic [3:0] be,
                                    input logic [7:0] ofs);
    lane_hit = (dw == ofs[7:2]) && be[ofs[1:0]];
  endfunction

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    if (wr_in) begin
      if (lane_hit(dw_addr_in, be_in, `IOFW_OFS_BASE_LO)) begin
        st_nxt.base_nib = wdata_in[`IOFW_LO_NIB_MSB:`IOFW_LO_NIB_LSB];
      end
      if (lane_hit(dw_addr_in, be_in, `IOFW_OFS_LIMIT_LO)) begin
        st_nxt.limit_nib = wdata_in[15:12];
      end
      if (lane_hit(dw_addr_in, be_in, `IOFW_OFS_BASE_HI)) begin
        st_nxt.base_hi[7:0] = wdata_in[7:0];
      end
      if (lane_hit(dw_addr_in, be_in, `IOFW_OFS_BASE_HI + 8'h01)) begin
        st_nxt.base_hi[15:8] = wdata_in[15:8];
      end
      if (lane_hit(dw_addr_in, be_in, `IOFW_OFS_LIMIT_HI)) begin
        st_nxt.limit_hi[7:0] = wdata_in[23:16];
      end
      if (lane_hit(dw_addr_in, be_in, `IOFW_OFS_LIMIT_HI + 8'h01)) begin
        st_nxt.limit_hi[15:8] = wdata_in[31:24];
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      st_r <= '{base_nib: `IOFW_RST_NIB, limit_nib: `IOFW_RST_NIB,
                base_hi: `IOFW_RST_HI, limit_hi: `IOFW_RST_HI};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Read-back and effective window
  // ----------------------------------------------------------------------
  always_comb begin
    rdata_out = 32'h0000_0000;
    if (dw_addr_in == `IOFW_OFS_BASE_LO >> 2) begin
      rdata_out[15:0] = {st_r.limit_nib, `IOFW_LO_TYPE,
                         st_r.base_nib, `IOFW_LO_TYPE};
    end else if (dw_addr_in == `IOFW_OFS_BASE_HI >> 2) begin
      rdata_out = {st_r.limit_hi, st_r.base_hi};
    end
  end

  assign win.base = {st_r.base_hi, st_r.base_nib, `IOFW_BASE_FILL};
  assign win.limit = {st_r.limit_hi, st_r.limit_nib, `IOFW_LIMIT_FILL};

endmodule

//--- iofw_defines.svh
// Offsets, field positions and reset values of the I/O window decoder.
// Assumes inclusion by bare name from every file that needs a constant.
`ifndef IOFW_DEFINES_SVH
`define IOFW_DEFINES_SVH

// ----------------------------------------------------------------------
// Configuration offsets (byte offsets within the port's header)
// ----------------------------------------------------------------------
`define IOFW_OFS_BASE_LO 8'h1c
`define IOFW_OFS_LIMIT_LO 8'h1d
`define IOFW_OFS_BASE_HI 8'h30
`define IOFW_OFS_LIMIT_HI 8'h32

// ----------------------------------------------------------------------
// Field positions and constant fields
// ----------------------------------------------------------------------
`define IOFW_LO_NIB_MSB 7
`define IOFW_LO_NIB_LSB 4
`define IOFW_LO_TYPE 4'h1
`define IOFW_BASE_FILL 12'h000
`define IOFW_LIMIT_FILL 12'hfff
`define IOFW_GRAN_BITS 12
`define IOFW_ISA_HI_MSB 31
`define IOFW_ISA_HI_LSB 16
`define IOFW_ISA_BLK_MSB 9
`define IOFW_ISA_BLK_LSB 8

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define IOFW_RST_NIB 4'h0
`define IOFW_RST_HI 16'h0000

`endif

//--- iofw_io_decoder.sv
// Address routing decoder for a bridge with one primary and two secondary
// buses. Assumes the command and bridge control bits come from registers
// on the same clock, and that memory window hits are decoded elsewhere.
`include "iofw_defines.svh"

// Contract
// - Primary cycles inside a port's windows go down; secondary outside go up.
// - Addresses pass unchanged; anything not claimed downstream goes upstream.
// - First-bus cycle hitting only second port's windows goes to second bus.
// - Second-bus cycle hitting only first port's windows goes to first bus.
// - Primary I/O cycles are ignored while the I/O enable is clear.
// - Secondary cycles ignored without master enable; it enables I/O and memory.
// - Each secondary port has its own 32-bit, 4KB-granular I/O window.
// - Base above limit disables the window: nothing down, everything up.
// - Base bits 15:12 from offset 1Ch upper nibble; low nibble reads 1h.
// - Base bits 31:16 from the writable 16-bit register at 30h.
// - Limit from 1Dh nibble and 32h halfword; low twelve bits are FFFh.
// - Reset gives base 0000_0000h and limit 0000_0FFFh.
// - ISA filtering only inside the window and below 64KB.
// - ISA mode passes down only the lowest 256 bytes of each 1KB.
// - ISA mode with master enable sends the upper 768 bytes upstream.
// - At or above 64KB only base and limit decide.
// - Other secondary I/O goes upstream only outside that port's window.
// - Memory goes downstream only while the memory enable is set.
module iofw_io_decoder #(
  parameter int unsigned PORTS = 2
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic cfg_wr_in,
  input wire logic cfg_rd_in,
  input wire logic cfg_port_in,
  input wire logic [5:0] cfg_dw_addr_in,
  input wire logic [3:0] cfg_be_in,
  input wire logic [31:0] cfg_wdata_in,
  output logic [31:0] cfg_rdata_out,
  output logic cfg_ack_out,
  input wire logic [1:0] io_enable_in,
  input wire logic [1:0] mem_enable_in,
  input wire logic [1:0] master_enable_in,
  input wire logic [1:0] isa_enable_in,
  input wire logic req_valid_in,
  input wire iofw_pkg::iofw_bus_t req_origin_in,
  input wire logic req_is_io_in,
  input wire logic [31:0] req_addr_in,
  input wire logic [1:0] mem_win_hit_in,
  output logic dec_valid_out,
  output logic dec_claim_out,
  output iofw_pkg::iofw_bus_t dec_dest_out,
  output logic [31:0] dec_addr_out,
  output logic [1:0] io_win_off_out
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  // The routing below names exactly two secondary ports.
  if (PORTS != 2) begin : g_bad_ports
    $error("iofw_io_decoder serves exactly two secondary ports");
  end

  // ----------------------------------------------------------------------
  // Per-port window registers and comparators
  // ----------------------------------------------------------------------
  logic [31:0] port_rdata [PORTS];
  logic [PORTS-1:0] io_hit;
  logic [PORTS-1:0] win_off;

  for (genvar p = 0; p < PORTS; p++) begin : g_port
    iofw_win_if win ();
    logic port_wr;

    assign port_wr = cfg_wr_in && (cfg_port_in == 1'(p));

    iofw_cfg_regs u_regs (
      .core_clk_in (core_clk_in),
      .rst_n_in (rst_n_in),
      .wr_in (port_wr),
      .dw_addr_in (cfg_dw_addr_in),
      .be_in (cfg_be_in),
      .wdata_in (cfg_wdata_in),
      .rdata_out (port_rdata[p]),
      .win (win.src)
    );

    iofw_win_hit u_hit (
      .win (win.snk),
      .addr_in (req_addr_in),
      .isa_enable_in (isa_enable_in[p]),
      .ds_hit_out (io_hit[p]),
      .win_off_out (win_off[p])
    );
  end

  // ----------------------------------------------------------------------
  // Routing
  // ----------------------------------------------------------------------
  // Destination of a cycle started on the primary bus. When both ports
  // claim an address the first one wins; overlapping windows are a
  // software error and this keeps the answer deterministic.
  function automatic iofw_pkg::iofw_bus_t route_down(
      input logic [1:0] hit,
      input logic [1:0] en);
    route_down = iofw_pkg::iofw_bus_none;
    if (hit[0] && en[0]) begin
      route_down = iofw_pkg::iofw_bus_sec1;
    end else if (hit[1] && en[1]) begin
      route_down = iofw_pkg::iofw_bus_sec2;
    end
  endfunction

  // Destination of a cycle started on secondary bus own (0 or 1).
  function automatic iofw_pkg::iofw_bus_t route_up(
      input logic own,
      input logic [1:0] hit,
      input logic [1:0] mst);
    logic mine;
    logic peer;
    mine = own ? hit[1] : hit[0];
    peer = own ? hit[0] : hit[1];
    route_up = iofw_pkg::iofw_bus_none;
    if (!(own ? mst[1] : mst[0])) begin
      route_up = iofw_pkg::iofw_bus_none;
    end else if (mine) begin
      // The target sits on the originating bus, so stay off the cycle.
      route_up = iofw_pkg::iofw_bus_none;
    end else if (peer) begin
      route_up = own ? iofw_pkg::iofw_bus_sec1 : iofw_pkg::iofw_bus_sec2;
    end else begin
      // ISA alias addresses fail the own hit and land here unless the peer window claims them.
      route_up = iofw_pkg::iofw_bus_pri;
    end
  endfunction

  logic [1:0] sel_hit;
  logic [1:0] sel_en;
  iofw_pkg::iofw_bus_t dest;

  always_comb begin
    sel_hit = req_is_io_in ? io_hit : mem_win_hit_in;
    sel_en = req_is_io_in ? io_enable_in : mem_enable_in;
    unique case (req_origin_in)
      iofw_pkg::iofw_bus_pri: begin
        dest = route_down(sel_hit, sel_en);
      end
      iofw_pkg::iofw_bus_sec1: begin
        dest = route_up(1'b0, sel_hit, master_enable_in);
      end
      iofw_pkg::iofw_bus_sec2: begin
        dest = route_up(1'b1, sel_hit, master_enable_in);
      end
      default: begin
        dest = iofw_pkg::iofw_bus_none;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  iofw_pkg::iofw_top_state_t st_r;
  iofw_pkg::iofw_top_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.cfg_ack = cfg_wr_in || cfg_rd_in;
    if (cfg_rd_in) begin
      st_nxt.cfg_rdata = port_rdata[cfg_port_in];
    end
    st_nxt.dec_valid = req_valid_in;
    if (req_valid_in) begin
      st_nxt.dec_dest = dest;
      st_nxt.dec_claim = dest != iofw_pkg::iofw_bus_none;
      st_nxt.dec_addr = req_addr_in;
    end
    st_nxt.win_off = win_off;
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      st_r <= '{cfg_rdata: 32'h0000_0000, cfg_ack: 1'b0, dec_valid: 1'b0,
                dec_claim: 1'b0, dec_dest: iofw_pkg::iofw_bus_none,
                dec_addr: 32'h0000_0000, win_off: 2'h0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign cfg_rdata_out = st_r.cfg_rdata;
  assign cfg_ack_out = st_r.cfg_ack;
  assign dec_valid_out = st_r.dec_valid;
  assign dec_claim_out = st_r.dec_claim;
  assign dec_dest_out = st_r.dec_dest;
  assign dec_addr_out = st_r.dec_addr;
  assign io_win_off_out = st_r.win_off;

endmodule

//--- iofw_io_decoder_bench.sv
// Self-checking bench for the I/O forwarding decoder.
// Assumes the bus agent and the bound checker are compiled before it.
module iofw_io_decoder_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cw = 1'b0, cr = 1'b0, cp = 1'b0, ack, rv, io, dv, dc;
  logic [5:0] dw = 6'h00;
  logic [3:0] be = 4'h0;
  logic [31:0] wd = 32'h0, rd, da, ra;
  logic [31:0] seed = 32'h3472;
  logic [1:0] ioe = 2'b00, me = 2'b00, ms = 2'b00, isa = 2'b00, mh, off;
  iofw_pkg::iofw_bus_t ro, dd;
  logic [31:0] bb [2] = '{32'h0, 32'h0};
  logic [31:0] ll [2] = '{32'hfff, 32'hfff};
  int errors = 0, samples_checked = 0;

  iofw_bus_agent agent_u (.core_clk_in(clk), .req_valid_out(rv),
    .req_origin_out(ro), .req_is_io_out(io), .req_addr_out(ra),
    .mem_win_hit_out(mh));
  iofw_io_decoder dut_u (.core_clk_in(clk), .rst_n_in(rst_n),
    .cfg_wr_in(cw), .cfg_rd_in(cr), .cfg_port_in(cp), .cfg_dw_addr_in(dw),
    .cfg_be_in(be), .cfg_wdata_in(wd), .cfg_rdata_out(rd), .cfg_ack_out(ack),
    .io_enable_in(ioe), .mem_enable_in(me), .master_enable_in(ms),
    .isa_enable_in(isa), .req_valid_in(rv), .req_origin_in(ro),
    .req_is_io_in(io), .req_addr_in(ra), .mem_win_hit_in(mh),
    .dec_valid_out(dv), .dec_claim_out(dc), .dec_dest_out(dd),
    .dec_addr_out(da), .io_win_off_out(off));

  initial forever #25 clk = ~clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Reference routing: 01/10 are the secondary buses, 00 primary, 11 none.
  function automatic logic [1:0] model(input logic [1:0] o, input logic i,
      input logic [31:0] a, input logic [1:0] m);
    logic [1:0] h, en;
    int s;
    for (int p = 0; p < 2; p++)
      h[p] = i ? (bb[p] <= a && a <= ll[p] && !(isa[p] && a[31:16] == 16'h0
        && a[9:8] != 2'b00)) : m[p];
    en = i ? ioe : me;
    if (o == 2'b00) return (h[0] && en[0]) ? 2'b01 : (h[1] && en[1]) ? 2'b10 : 2'b11;
    if (o == 2'b11) return 2'b11;
    s = int'(o) - 1;
    if (!ms[s] || h[s]) return 2'b11;
    if (h[1 - s]) return (s == 1) ? 2'b01 : 2'b10;
    return 2'b00;
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic cfg(input logic w, input logic p, input logic [5:0] a,
      input logic [3:0] b, input logic [31:0] d, input logic [31:0] e);
    @(negedge clk);
    {cw, cr, cp, dw, be, wd} = {w, !w, p, a, b, d};
    @(negedge clk);
    {cw, cr} = 2'b00;
    chk(32'(ack), 32'h1);
    if (!w) chk(rd, e);
  endtask

  task automatic req(input logic [1:0] o, input logic i,
      input logic [31:0] a, input logic [1:0] m, input int g);
    logic [1:0] e;
    e = model(o, i, a, m);
    agent_u.issue(o, i, a, m, g);
    chk(32'(dv), 32'h1);
    chk(32'(dd), 32'(e));
    chk(32'(dc), 32'(e != 2'b11));
    chk(da, a);
    chk(32'(off), {30'h0, ll[1] < bb[1], ll[0] < bb[0]});
  endtask

  task automatic burst(input int n);
    repeat (n) begin
      repeat (16) seed = lfsr(seed);
      {isa, ms, me, ioe} = seed[7:0];
      req(seed[9:8], seed[10], {14'h0, seed[11], 1'b0, seed[31:16]},
        seed[13:12], int'(seed[15:14]));
    end
    $display("random burst of %0d done", n);
  endtask

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    tally_and_finish;
  end

  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    cfg(0, 0, 6'h07, 4'h0, 0, 32'h0000_0101);
    cfg(0, 1, 6'h0c, 4'h0, 0, 32'h0);
    ioe = 2'b01;
    req(0, 1, 32'h0000_0fff, 0, 0);
    req(0, 1, 32'h0000_1000, 0, 0);
    ioe = 2'b00;
    cfg(1, 0, 6'h07, 4'h3, 32'hffff_403e, 0);
    cfg(0, 0, 6'h07, 4'h0, 0, 32'h0000_4131);
    cfg(1, 0, 6'h0c, 4'hf, 32'h0002_0002, 0);
    cfg(0, 0, 6'h0c, 4'h0, 0, 32'h0002_0002);
    cfg(1, 1, 6'h07, 4'h2, 32'h0000_f000, 0);
    cfg(1, 1, 6'h10, 4'hf, 32'hffff_ffff, 0);
    cfg(0, 1, 6'h10, 4'h0, 0, 0);
    bb[0] = 32'h0002_3000;
    ll[0] = 32'h0002_4fff;
    ll[1] = 32'h0000_ffff;
    {isa, ms, me, ioe} = 8'h3f;
    req(1, 1, 32'h0000_8000, 0, 0);
    req(2, 1, 32'h0002_3000, 0, 1);
    isa = 2'b10;
    req(2, 1, 32'h0000_0200, 0, 0);
    req(0, 1, 32'h0000_0600, 0, 0);
    $display("directed routing done");
    burst(150);
    {ioe, ms} = 4'h0;
    cfg(1, 0, 6'h07, 4'h1, 32'h0000_0050, 0);
    bb[0] = 32'h0002_5000;
    burst(150);
    tally_and_finish;
  end
endmodule

//--- iofw_io_decoder_properties.sv
// Timing and routing properties of the I/O forwarding decoder.
// Assumes a bind onto iofw_io_decoder; sees only that module's ports.
module iofw_io_decoder_properties (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic cfg_wr_in,
  input wire logic cfg_rd_in,
  input wire logic cfg_ack_out,
  input wire logic [1:0] io_enable_in,
  input wire logic [1:0] mem_enable_in,
  input wire logic [1:0] master_enable_in,
  input wire logic req_valid_in,
  input wire iofw_pkg::iofw_bus_t req_origin_in,
  input wire logic req_is_io_in,
  input wire logic [31:0] req_addr_in,
  input wire logic dec_valid_out,
  input wire logic dec_claim_out,
  input wire iofw_pkg::iofw_bus_t dec_dest_out,
  input wire logic [31:0] dec_addr_out
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  localparam iofw_pkg::iofw_bus_t bus_no = iofw_pkg::iofw_bus_none;
  wire logic from_pri = req_valid_in && req_origin_in == iofw_pkg::iofw_bus_pri;
  wire logic from_first = req_valid_in && req_origin_in == iofw_pkg::iofw_bus_sec1;
  wire logic from_second = req_valid_in && req_origin_in == iofw_pkg::iofw_bus_sec2;

  dec_pulse_a: assert property (req_valid_in |=> dec_valid_out)
    else $error("decode answer missing");
  addr_pass_a: assert property (req_valid_in |=> dec_addr_out == $past(req_addr_in))
    else $error("forwarded address altered");
  result_hold_a: assert property (!req_valid_in |=> $stable(dec_dest_out) && $stable(dec_addr_out))
    else $error("decode result moved without request");
  claim_match_a: assert property (dec_claim_out == (dec_dest_out != bus_no))
    else $error("claim disagrees with destination");
  io_gate_a: assert property (from_pri && req_is_io_in && io_enable_in == 2'b00 |=> dec_dest_out == bus_no)
    else $error("primary io forwarded while disabled");
  mem_gate_a: assert property (from_pri && !req_is_io_in && mem_enable_in == 2'b00 |=> dec_dest_out == bus_no)
    else $error("primary memory forwarded while disabled");
  master_gate_a: assert property ((from_first && !master_enable_in[0]) || (from_second && !master_enable_in[1]) |=> dec_dest_out == bus_no)
    else $error("secondary cycle forwarded without master enable");
  no_echo_a: assert property (req_valid_in && req_origin_in != bus_no |=> dec_dest_out != $past(req_origin_in))
    else $error("cycle routed back to its own bus");
  cfg_ack_a: assert property (cfg_wr_in || cfg_rd_in |=> cfg_ack_out)
    else $error("config access not acknowledged");

  down_c: cover property (from_pri ##1 dec_claim_out);
  peer_c: cover property (from_first ##1 dec_dest_out == iofw_pkg::iofw_bus_sec2);
  up_c: cover property (from_second ##1 dec_dest_out == iofw_pkg::iofw_bus_pri);
endmodule

bind iofw_io_decoder iofw_io_decoder_properties chk_u (.core_clk_in, .rst_n_in,
  .cfg_wr_in, .cfg_rd_in, .cfg_ack_out, .io_enable_in, .mem_enable_in,
  .master_enable_in, .req_valid_in, .req_origin_in, .req_is_io_in,
  .req_addr_in, .dec_valid_out, .dec_claim_out, .dec_dest_out, .dec_addr_out);

//--- iofw_pkg.sv
// Types shared by the I/O window decoder modules.
// Assumes nothing beyond a SystemVerilog compiler.
package iofw_pkg;

  // Bus identities, used both for where a cycle starts and where it goes.
  typedef enum logic [1:0] {
    iofw_bus_pri = 2'b00,
    iofw_bus_sec1 = 2'b01,
    iofw_bus_sec2 = 2'b10,
    iofw_bus_none = 2'b11
  } iofw_bus_t;

  typedef struct packed {
    logic [3:0] base_nib;
    logic [3:0] limit_nib;
    logic [15:0] base_hi;
    logic [15:0] limit_hi;
  } iofw_win_regs_t;

  typedef struct packed {
    logic [31:0] cfg_rdata;
    logic cfg_ack;
    logic dec_valid;
    logic dec_claim;
    iofw_bus_t dec_dest;
    logic [31:0] dec_addr;
    logic [1:0] win_off;
  } iofw_top_state_t;

endpackage

//--- iofw_win_hit.sv
// Decides whether an I/O address is claimed downstream by one port.
// Assumes a window already expanded to full 32-bit base and limit.
`include "iofw_defines.svh"

module iofw_win_hit (
  iofw_win_if.snk win,
  input wire logic [31:0] addr_in,
  input wire logic isa_enable_in,
  output logic ds_hit_out,
  output logic win_off_out
);

  logic in_win;
  logic low_64k;
  logic isa_alias;

  // A base above the limit leaves no address satisfying both compares.
  assign in_win = (addr_in >= win.base) && (addr_in <= win.limit);
  assign win_off_out = win.base > win.limit;
  assign low_64k = addr_in[`IOFW_ISA_HI_MSB:`IOFW_ISA_HI_LSB] == 16'h0000;
  assign isa_alias = addr_in[`IOFW_ISA_BLK_MSB:`IOFW_ISA_BLK_LSB] != 2'h0;
  // Above 64KB only the window counts.
  assign ds_hit_out = in_win && !(isa_enable_in && low_64k && isa_alias);

endmodule

//--- iofw_win_if.sv
// Carries one port's effective I/O window from its registers to its
// address comparator. Assumes both ends share the decoder's clock.
interface iofw_win_if;
  logic [31:0] base;
  logic [31:0] limit;

  modport src (output base, output limit);
  modport snk (input base, input limit);
endinterface
